/* File: core/otp_lock_ctrl.sv */
// otp mode and lock register control of a serial nor flash
// assumes sclk stands still while cs_n is high, and that the
// flash core acts on cmd when cmd_valid pulses
// How it works
// - an exact one-byte enter opcode switches the access target to the otp area
// - in otp mode read and program frames are passed on aimed at the otp area
// - in otp mode no frame is ever passed on aimed at the main array
// - an exact one-byte exit opcode returns the access target to the main array
// - in otp mode the status write and lock write opcodes are refused
// - once the customer lock is set only reads are granted in otp mode
// - the lock read opcode streams the lock byte on so at any time, repeating
// - lock bit0 shows the factory lock input
// - the customer lock bit, once 1, stays 1 and blocks otp writes for good
// - the lock write opcode alone sets the customer lock, with no latch check
// - the write enable latch is neither needed nor consulted for lock writes
// - a lock write whose frame is not exactly one byte is rejected
// - after reset the part is in standby with the write enable latch clear
`timescale 1ns/1ns
`default_nettype none
`include "otp_lock_cfg.svh"
module otp_lock_ctrl #(
    parameter logic [7:0] ENTER_OP = 8'h01,
    parameter logic [7:0] EXIT_OP = 8'h02,
    parameter logic [7:0] RDLOCK_OP = 8'h03,
    parameter logic [7:0] WRLOCK_OP = 8'h04,
    parameter logic [7:0] WRITE_ENABLE_CMD_OP = 8'h05,
    parameter logic [7:0] WRITE_STATUS_CMD_OP = 8'h06,
    parameter logic [7:0] READ_OP = 8'h07,
    parameter logic [7:0] PP_OP = 8'h08,
    parameter logic [7:0] ERASE_OP = 8'h09,
    parameter logic [7:0] DP_OP = 8'h0A,
    parameter logic [7:0] RDP_OP = 8'h0B
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic factory_lock,
    input wire logic cust_lock_nv,
    input wire logic busy,
    output logic so,
    output logic so_oe_n,
    output logic cmd_valid,
    output otp_lock_pkg::cmd_t cmd,
    output logic otp_mode,
    output logic write_enable_latch,
    output logic deep_pd,
    output logic lock_prog
);
    import otp_lock_pkg::*;

    // refuse opcode sets in which ENTER_OP and EXIT_OP, RDLOCK_OP and WRLOCK_OP, or PP_OP and READ_OP match
    if (ENTER_OP == EXIT_OP || RDLOCK_OP == WRLOCK_OP || PP_OP == READ_OP) begin : g_op_clash
        $error("opcode parameters collide");
    end
    // the bit and byte counters are written for three bit fields
    if (`FRAME_CNT_W != 3) begin : g_cnt_width
        $error("frame counter width unsupported");
    end

    // ******************************
    // lock register view
    // ******************************
    // the stored lock values come from the array side, not from clk logic,
    // so they pass two flops before anything reads them
    logic [1:0] lock_pin_s1;
    logic [1:0] lock_pin_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_pin_s1 <= 2'h0;
            lock_pin_s2 <= 2'h0;
        end else begin
            lock_pin_s1 <= {cust_lock_nv, factory_lock};
            lock_pin_s2 <= lock_pin_s1;
        end
    end

    logic cust_set;
    wire cust_lock = lock_pin_s2[1] | cust_set;
    wire [7:0] lock_val = {`LOCK_RESERVED_RESET, cust_lock, lock_pin_s2[0]};

    // ******************************
    // link side, clocked by sclk
    // ******************************
    // the shifter restarts at the first sclk rise of each frame; opcode and
    // length stay put after cs_n rises so the clk side can still decode them
    wire frame_rst_n = rst_n & ~cs_n;
    logic [7:0] shreg;
    logic [7:0] opcode;
    frame_len_t flen;
    logic fresh;
    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n)
            fresh <= 1'b1;
        else
            fresh <= 1'b0;
    end
    wire [7:0] cur_shreg = fresh ? 8'h00 : shreg;
    wire [`FRAME_CNT_W-1:0] cur_bit = fresh ? {`FRAME_CNT_W{1'b0}} : flen.bit_mod;
    wire [`FRAME_CNT_W-1:0] cur_nbyte = fresh ? {`FRAME_CNT_W{1'b0}} : flen.nbyte;
    wire [7:0] next_shreg = {cur_shreg[6:0], si};
    wire byte_done = (cur_bit == 3'h7);
    wire [`FRAME_CNT_W-1:0] next_nbyte = (cur_nbyte == 3'h7) ? cur_nbyte : cur_nbyte + 3'h1;

    // a frame cut mid-byte leaves bit_mod off zero, which every decode but the read refuses
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 8'h00;
            opcode <= 8'h00;
            flen <= '0;
        end else begin
            shreg <= next_shreg;
            flen.bit_mod <= cur_bit + 3'h1;
            flen.nbyte <= byte_done ? next_nbyte : cur_nbyte;
            if (byte_done && cur_nbyte == 3'h0)
                opcode <= next_shreg;
        end
    end

    // lock_val follows the synchronised lock inputs on every clk edge and cust_set at frame end,
    // so it is steady for a frame that reads it only while those inputs hold
    wire rd_active = (flen.nbyte != 3'h0) && (opcode == RDLOCK_OP);

    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so <= rd_active & lock_val[3'h7 - flen.bit_mod];
            so_oe_n <= ~rd_active;
        end
    end

    // ******************************
    // frame end crossing into clk
    // ******************************
    // opcode and flen are frozen once cs_n is high, so reading them
    // after the synchronised rise is safe
    logic cs_s1, cs_s2, cs_s3;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end
    wire frame_end = cs_s2 & ~cs_s3;

    // ******************************
    // decode
    // ******************************
    wire on_bound = (flen.bit_mod == 3'h0);
    wire exact1 = on_bound && (flen.nbyte == 3'(`OPCODE_BYTES));
    wire addr_ok = flen.nbyte >= 3'(`OPCODE_BYTES + `ADDR_BYTES);
    wire pp_len_ok = on_bound && (flen.nbyte >= 3'(`PP_MIN_BYTES));
    wire er_len_ok = on_bound && (flen.nbyte == 3'(`OPCODE_BYTES + `ADDR_BYTES));
    wire is_enter = (opcode == ENTER_OP);
    wire is_exit = (opcode == EXIT_OP);
    wire is_wrlock = (opcode == WRLOCK_OP);
    wire is_write_enable_cmd = (opcode == WRITE_ENABLE_CMD_OP);
    wire is_write_status_cmd = (opcode == WRITE_STATUS_CMD_OP);
    wire is_read = (opcode == READ_OP);
    wire is_pp = (opcode == PP_OP);
    wire is_erase = (opcode == ERASE_OP);
    wire is_dp = (opcode == DP_OP);
    wire is_rdp = (opcode == RDP_OP);
    // a busy core refuses all but the lock read stream; deep power-down also takes the RDP_OP frame
    wire live = ~deep_pd & ~busy;

    wire ok_enter = live & is_enter & exact1;
    wire ok_exit = live & is_exit & exact1;
    // no wel term here on purpose
    wire ok_wrlock = live & is_wrlock & exact1 & ~otp_mode & ~cust_lock;
    wire ok_write_status_cmd = live & is_write_status_cmd & exact1 & write_enable_latch & ~otp_mode;
    wire ok_read = live & is_read & addr_ok;
    wire ok_pp = live & is_pp & pp_len_ok & write_enable_latch & ~(otp_mode & cust_lock);
    // the otp area offers no erase; the main array does
    wire ok_erase = live & is_erase & er_len_ok & write_enable_latch & ~otp_mode;
    wire ok_write_enable_cmd = live & is_write_enable_cmd & exact1;
    wire ok_dp = live & is_dp & exact1;
    wire ok_rdp = ~busy & is_rdp & exact1;
    wire clr_wel = ok_write_status_cmd | ok_pp | ok_erase;
    // refused pass-on frames still pulse cmd_valid so the core can drop them
    wire pass_on = is_read | is_pp | is_erase | is_write_status_cmd;

    wire next_granted = ok_read | ok_pp | ok_erase | ok_write_status_cmd;
    wire next_otp_mode = ok_enter ? 1'b1 : (ok_exit ? 1'b0 : otp_mode);
    wire next_wel = ok_write_enable_cmd ? 1'b1 : (clr_wel ? 1'b0 : write_enable_latch);
    wire next_deep_pd = ok_dp ? 1'b1 : (ok_rdp ? 1'b0 : deep_pd);

    // ******************************
    // control state
    // ******************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_mode <= 1'b0;
            write_enable_latch <= 1'b0;
            deep_pd <= 1'b0;
            cust_set <= 1'b0;
        end else if (frame_end) begin
            otp_mode <= next_otp_mode;
            write_enable_latch <= next_wel;
            deep_pd <= next_deep_pd;
            cust_set <= cust_set | ok_wrlock;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd <= '0;
            lock_prog <= 1'b0;
        end else begin
            cmd_valid <= frame_end & pass_on;
            lock_prog <= frame_end & ok_wrlock;
            if (frame_end) begin
                cmd.granted <= next_granted;
                cmd.otp_target <= otp_mode;
                cmd.opcode <= opcode;
            end
        end
    end

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    otp_enter_a: assert property (frame_end && is_enter && exact1 && !deep_pd && !busy |=> otp_mode)
        else $error("enter opcode did not select otp");
    otp_exit_a: assert property (frame_end && ok_exit && !ok_enter |=> !otp_mode)
        else $error("exit opcode did not leave otp");
    otp_target_a: assert property (cmd_valid |-> cmd.otp_target == $past(otp_mode))
        else $error("frame aimed at wrong area");
    otp_no_wsr_a: assert property (cmd_valid && cmd.opcode == WRITE_STATUS_CMD_OP && cmd.otp_target |-> !cmd.granted)
        else $error("status write granted in otp mode");
    locked_ro_a: assert property (
        cmd_valid && cmd.otp_target && $past(cust_lock) && cmd.opcode != READ_OP |-> !cmd.granted)
        else $error("otp write granted after lock");
    lock_sticky_a: assert property (cust_set |=> cust_set [*3])
        else $error("customer lock cleared");
    lock_no_wel_a: assert property (
        frame_end && is_wrlock && exact1 && !otp_mode && !deep_pd && !busy && !write_enable_latch && !cust_lock
        |=> cust_set && lock_prog)
        else $error("lock write failed without latch");
    lock_boundary_a: assert property (frame_end && is_wrlock && !exact1 && !cust_set |=> !cust_set && !lock_prog)
        else $error("misaligned lock write executed");
    lock_otp_refuse_a: assert property (frame_end && is_wrlock && otp_mode && !cust_set |=> !cust_set)
        else $error("lock write taken in otp mode");

    lock_once_a: assert property (
        lock_prog |-> !$past(cust_set))
        else $error("customer lock written twice");
    lock_locked_a: assert property (
        frame_end && is_wrlock && cust_lock |=> !lock_prog)
        else $error("lock write taken after lock");
    lock_wel_set_a: assert property (
        frame_end && is_wrlock && exact1 && !otp_mode && !deep_pd && !busy && write_enable_latch && !cust_lock |=> lock_prog)
        else $error("lock write failed with latch set");
    otp_no_erase_a: assert property (
        cmd_valid && cmd.otp_target && cmd.opcode == ERASE_OP |-> !cmd.granted)
        else $error("erase granted on otp area");
    read_grant_a: assert property (
        frame_end && is_read && addr_ok && !deep_pd && !busy |=> cmd_valid && cmd.granted)
        else $error("read frame not granted");
    pp_wel_a: assert property (
        cmd_valid && cmd.granted && cmd.opcode == PP_OP |-> $past(write_enable_latch) && !write_enable_latch)
        else $error("program granted without latch");
    mode_hold_a: assert property (
        frame_end && !ok_enter && !ok_exit |=> otp_mode == $past(otp_mode))
        else $error("otp mode moved without command");
    main_blocked_a: assert property (
        cmd_valid && $past(otp_mode) |-> cmd.otp_target)
        else $error("main array reached in otp mode");

    // ******************************
    // cover points
    // ******************************
    enter_seen_c: cover property (frame_end && ok_enter ##[1:200] frame_end && ok_exit);
    lock_done_c: cover property (lock_prog);
    otp_pp_c: cover property (cmd_valid && cmd.granted && cmd.otp_target && cmd.opcode == PP_OP);
    lock_read_c: cover property (frame_end && opcode == RDLOCK_OP);
    otp_refuse_c: cover property (cmd_valid && cmd.otp_target && !cmd.granted);
endmodule : otp_lock_ctrl
`default_nettype wire

/* File: core/otp_lock_cfg.svh */
// constants for the otp lock control block
// assumes a single include per compile unit, guarded below
`ifndef OTP_LOCK_CFG_SVH
`define OTP_LOCK_CFG_SVH
`define OTP_AREA_BITS 512
`define LOCK_FACTORY_POS 0
`define LOCK_CUST_POS 1
`define LOCK_RESERVED_RESET 6'h00
`define OPCODE_BYTES 1
`define ADDR_BYTES 3
`define PP_MIN_BYTES 5
`define FRAME_CNT_W 3
`endif

/* File: core/otp_lock_pkg.sv */
// types shared by the otp lock control block
// assumes otp_lock_cfg.svh is on the include path
`include "otp_lock_cfg.svh"
package otp_lock_pkg;
    // one decoded frame handed to the flash core
    typedef struct packed {
        logic granted;
        logic otp_target;
        logic [7:0] opcode;
    } cmd_t;
    // frame length as seen on the serial link
    typedef struct packed {
        logic [`FRAME_CNT_W-1:0] nbyte;
        logic [`FRAME_CNT_W-1:0] bit_mod;
    } frame_len_t;
endpackage : otp_lock_pkg

/* File: verif/flash_host.sv */
// host side model of the serial link: frames on cs_n, sclk and si
// assumes the device launches so on sclk fall; sclk stands still between frames
`timescale 1ns/1ns
`default_nettype none
module flash_host (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    // ****************
    // frame generator
    // ****************
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // nb bits of d go out msb first, then nr more clocks collect so
    task automatic frame(input logic [39:0] d, input int nb, input int nr, output logic [15:0] rd);
        int i;
        rd = 16'h0000;
        cs_n = 1'b0;
        for (i = 0; i < nb + nr; i++) begin
            si = (i < nb) ? d[39 - i] : ~si;
            #32 sclk = 1'b1;
            if (i >= nb) rd = {rd[14:0], so};
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        // released line: no stale value left behind
        si = ~si;
        #120;
    endtask : frame
endmodule : flash_host
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for otp_lock_ctrl
// assumes the host model drives the link and opcodes set below
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import otp_lock_pkg::*;
    // ****************
    // setup
    // ****************
    localparam logic [7:0] OP_EN = 8'h01, OP_EX = 8'h02, OP_RDL = 8'h03, OP_WRL = 8'h04;
    localparam logic [7:0] OP_WE = 8'h05, OP_STW = 8'h06, OP_RD = 8'h07, OP_PROG = 8'h08;
    logic clk, rst_n, sclk, cs_n, si, factory_lock, cust_lock_nv, busy;
    logic so, so_oe_n, cmd_valid, otp_mode, write_enable_latch, deep_pd, lock_prog;
    cmd_t cmd;
    logic [15:0] rd;
    logic [31:0] rs = 32'd45;
    logic [19:0] exp_q[$];
    logic [19:0] e;
    int bad_count = 0, cmp_count = 0, prog_seen = 0;
    otp_lock_ctrl #(.ENTER_OP(OP_EN), .EXIT_OP(OP_EX), .RDLOCK_OP(OP_RDL), .WRLOCK_OP(OP_WRL),
        .WRITE_ENABLE_CMD_OP(OP_WE), .WRITE_STATUS_CMD_OP(OP_STW), .READ_OP(OP_RD), .PP_OP(OP_PROG)) u_otp_lock_ctrl (
        .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .si(si), .factory_lock(factory_lock),
        .cust_lock_nv(cust_lock_nv), .busy(busy), .so(so), .so_oe_n(so_oe_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .otp_mode(otp_mode), .write_enable_latch(write_enable_latch), .deep_pd(deep_pd), .lock_prog(lock_prog));
    flash_host u_flash_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [31:0] got, input logic [31:0] ex);
        cmp_count++;
        if (got !== ex) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, ex);
        end
    endtask : check
    task automatic fr(input logic [39:0] d, input int nb, input int nr);
        rs = xs(rs);
        u_flash_host.frame(d | {8'h00, rs}, nb, nr, rd);
    endtask : fr
    // expected cmd {granted, otp_target, opcode} with a mask of the bits that matter
    task automatic note(input logic [9:0] ex, input logic [9:0] m);
        exp_q.push_back({m, ex});
    endtask : note
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // ****************
    // monitor and stimulus
    // ****************
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hFFFFF;
            check(32'(cmd & e[19:10]), 32'(e[9:0]));
        end
        if (lock_prog === 1'b1) prog_seen++;
    end
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        busy = 1'b0;
        cust_lock_nv = 1'b0;
        factory_lock = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        rs = xs(rs);
        factory_lock = rs[0];
        repeat (4) @(negedge clk);
        check(32'({otp_mode, write_enable_latch, deep_pd}), 32'h0);
        busy = 1'b1;
        fr({OP_RDL, 32'h0}, 8, 16);
        check(32'(rd), 32'({2{7'h00, factory_lock}}));
        @(negedge clk) busy = 1'b0;
        note({2'b10, OP_RD}, 10'h3FF);
        fr({OP_RD, 32'h0}, 32, 8);
        fr({OP_EN, 32'h0}, 8, 0);
        check(32'(otp_mode), 32'h1);
        note({2'b11, OP_RD}, 10'h3FF);
        fr({OP_RD, 32'h0}, 32, 8);
        fr({OP_WE, 32'h0}, 8, 0);
        note({2'b01, OP_STW}, 10'h3FF);
        fr({OP_STW, 32'h0}, 8, 0);
        fr({OP_WRL, 32'h0}, 8, 0);
        check(32'(prog_seen), 32'h0);
        fr({OP_WE, 32'h0}, 8, 0);
        note({2'b11, OP_PROG}, 10'h3FF);
        fr({OP_PROG, 32'h0}, 40, 0);
        fr({OP_EX, 32'h0}, 8, 0);
        check(32'(otp_mode), 32'h0);
        fr({OP_WRL, 32'h0}, 9, 0);
        check(32'(prog_seen), 32'h0);
        fr({OP_WRL, 32'h0}, 8, 0);
        check(32'(prog_seen), 32'h1);
        fr({OP_RDL, 32'h0}, 8, 8);
        check(32'(rd), 32'({7'h01, factory_lock}));
        fr({OP_WRL, 32'h0}, 8, 0);
        fr({OP_EN, 32'h0}, 8, 0);
        fr({OP_WE, 32'h0}, 8, 0);
        note({2'b01, OP_PROG}, 10'h3FF);
        fr({OP_PROG, 32'h0}, 40, 0);
        note({2'b11, OP_RD}, 10'h3FF);
        fr({OP_RD, 32'h0}, 32, 8);
        check(32'(prog_seen), 32'h1);
        check(32'(exp_q.size()), 32'h0);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
